/* File: shared/hbp_pkg.sv */
// Shared constants and types of the host bus and parallel port block
package hbp_pkg;

   //---------------------------------------------------------------
   // Widths
   //---------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int GP_W   = 4;

   //---------------------------------------------------------------
   // Register indices (byte address in demultiplexed mode)
   //---------------------------------------------------------------
   localparam logic [7:0] OFS_EXT_MODE   = 8'h00;
   localparam logic [7:0] OFS_PORT_DIR   = 8'h01;
   localparam logic [7:0] OFS_BIDIR_DATA = 8'h02;
   localparam logic [7:0] OFS_INPUT_PORT = 8'h03;

   //---------------------------------------------------------------
   // Field positions and reset values
   //---------------------------------------------------------------
   localparam int         EVEN_SEL_BIT   = 0;
   localparam logic [7:0] RST_EXT_MODE   = 8'h00;
   localparam logic [3:0] RST_PORT_DIR   = 4'h0;
   localparam logic [3:0] RST_BIDIR_DATA = 4'h0;

   //---------------------------------------------------------------
   // Timing counts
   //---------------------------------------------------------------
   // Cycles after reset before the latch enable level is trusted
   localparam logic [2:0] ALE_SETTLE_CYC = 3'h4;

   //---------------------------------------------------------------
   // Enumerations
   //---------------------------------------------------------------
   typedef enum logic [1:0] {
      HBP_MODE_DEMUX_DS,
      HBP_MODE_DEMUX_RDWR,
      HBP_MODE_MUX
   } hbp_mode_e;

   typedef enum logic [1:0] {
      HBP_PH_IDLE,
      HBP_PH_READ,
      HBP_PH_WRITE
   } hbp_phase_e;

endpackage

/* File: core/hbp_mode_detect.sv */
// Bus style detection from the address latch enable pin
`timescale 1ns/10ps
`default_nettype none

module hbp_mode_detect (
   input  wire logic         ref_clk_in,
   input  wire logic         reset_in,
   input  wire logic         ale_in,
   output hbp_pkg::hbp_mode_e mode_out,
   output logic              mode_valid_out,
   output logic              ale_fall_out
);

   typedef struct packed {
      logic       ale_s1;
      logic       ale_s2;
      logic       ale_d;
      logic       muxed;
      logic [2:0] cnt;
      logic       valid;
   } hbp_md_s;

   hbp_md_s st_reg;
   hbp_md_s st_next;

   //---------------------------------------------------------------
   // Detection
   //---------------------------------------------------------------
   // Any edge on the pin after the settle count means multiplexed mode; it stays until reset
   // because a strapped pin never toggles.
   always_comb begin
      st_next        = st_reg;
      st_next.ale_s1 = ale_in;
      st_next.ale_s2 = st_reg.ale_s1;
      st_next.ale_d  = st_reg.ale_s2;
      if (st_reg.cnt != hbp_pkg::ALE_SETTLE_CYC) begin
         st_next.cnt = st_reg.cnt + 3'h1;
      end else begin
         st_next.valid = 1'b1;
         if (st_reg.ale_s2 != st_reg.ale_d) begin
            st_next.muxed = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_comb begin
      if (st_reg.muxed) begin
         mode_out = hbp_pkg::HBP_MODE_MUX;
      end else if (st_reg.ale_s2) begin
         mode_out = hbp_pkg::HBP_MODE_DEMUX_DS;
      end else begin
         mode_out = hbp_pkg::HBP_MODE_DEMUX_RDWR;
      end
   end

   assign mode_valid_out = st_reg.valid;
   assign ale_fall_out   = st_reg.muxed & st_reg.ale_d & ~st_reg.ale_s2;

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   a_toggle_muxes: assert property (
      (st_reg.valid && st_reg.ale_s2 != st_reg.ale_d) |=>
         mode_out == hbp_pkg::HBP_MODE_MUX)
      else $error("latch enable edge did not select multiplexed mode");

   a_static_style: assert property (
      (!st_reg.muxed && $stable(st_reg.ale_s2) && st_reg.ale_s2) |->
         mode_out == hbp_pkg::HBP_MODE_DEMUX_DS)
      else $error("latch enable high did not select strobe style");

endmodule

`default_nettype wire

/* File: core/hbp_gp_port.sv */
// Four-bit general-purpose port with per-bit direction
`timescale 1ns/10ps
`default_nettype none

module hbp_gp_port #(
   parameter int GP_W = hbp_pkg::GP_W
) (
   input  wire logic            ref_clk_in,
   input  wire logic            reset_in,
   input  wire logic            wr_dir_in,
   input  wire logic            wr_data_in,
   input  wire logic [GP_W-1:0] wdata_in,
   input  wire logic [GP_W-1:0] pins_in,
   output logic      [GP_W-1:0] pins_out,
   output logic      [GP_W-1:0] pins_oe_out,
   output logic      [GP_W-1:0] dir_out,
   output logic      [GP_W-1:0] data_rd_out
);

   typedef struct packed {
      logic [GP_W-1:0] dir;
      logic [GP_W-1:0] latch;
      logic [GP_W-1:0] s1;
      logic [GP_W-1:0] s2;
   } hbp_gp_s;

   hbp_gp_s st_reg;
   hbp_gp_s st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = pins_in;
      st_next.s2 = st_reg.s1;
      if (wr_dir_in) begin
         st_next.dir = wdata_in;
      end
      // The latch takes writes even on input bits, so a value can be
      // staged before the bit is turned round.
      if (wr_data_in) begin
         st_next.latch = wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_reg <= {hbp_pkg::RST_PORT_DIR, hbp_pkg::RST_BIDIR_DATA,
                    {GP_W{1'b0}}, {GP_W{1'b0}}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign pins_out    = st_reg.latch;
   assign pins_oe_out = st_reg.dir;
   assign dir_out     = st_reg.dir;
   // Input bits show the pin, output bits the driven value
   assign data_rd_out = (st_reg.dir & st_reg.latch) |
                        (~st_reg.dir & st_reg.s2);

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   a_dir_write: assert property (
      wr_dir_in |=> dir_out == $past(wdata_in))
      else $error("direction write not taken");

   a_input_reflect: assert property (
      ((dir_out == '0) && $stable(pins_in) [*3]) |->
         data_rd_out == pins_in)
      else $error("input bits do not reflect pins");

   a_drive_latch: assert property (
      wr_data_in |=>
         ((dir_out & (pins_out ^ $past(wdata_in))) == '0) &&
         (pins_oe_out == dir_out))
      else $error("output pin not driven with written value");

   a_out_readback: assert property (
      ((dir_out & (data_rd_out ^ pins_out)) == '0))
      else $error("output bit reads back wrong value");

endmodule

`default_nettype wire

/* File: core/hbp_host_bus.sv */
// Host microprocessor bus slave with parallel ports
`timescale 1ns/10ps
`default_nettype none

module hbp_host_bus (
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   input  wire logic        ale_in,
   input  wire logic        chip_select_group_a_n_in,
   input  wire logic        chip_select_group_b_n_in,
   input  wire logic        rd_data_strobe_n_in,
   input  wire logic        wr_or_rw_in,
   input  wire logic [7:0]  addr_port_pins_in,
   input  wire logic [7:0]  muxed_addr_data_bus_in,
   output logic      [7:0]  muxed_addr_data_bus_out,
   output logic      [7:0]  muxed_addr_data_bus_oe_out,
   input  wire logic [3:0]  gp_pins_in,
   output logic      [3:0]  gp_pins_out,
   output logic      [3:0]  gp_pins_oe_out,
   output logic             grp_b_rd_out,
   output logic             grp_b_wr_out,
   output logic      [7:0]  grp_b_addr_out,
   output logic      [7:0]  grp_b_wdata_out,
   input  wire logic [7:0]  grp_b_rdata_in
);

   typedef struct packed {
      logic [7:0]          addr_s1;
      logic [7:0]          addr_s2;
      logic [7:0]          ad_s1;
      logic [7:0]          ad_s2;
      logic                csa_s1;
      logic                csa_s2;
      logic                csb_s1;
      logic                csb_s2;
      logic                str_s1;
      logic                str_s2;
      logic                wrp_s1;
      logic                wrp_s2;
      logic [7:0]          addr_lat;
      hbp_pkg::hbp_phase_e phase;
      logic                grp_b;
      logic [7:0]          acc_addr;
      logic [7:0]          rdata;
      logic                drive;
      logic [7:0]          wdata;
      logic [7:0]          input_port_data_lat;
      logic [7:0]          ext_mode;
      logic                b_rd;
      logic                b_wr;
   } hbp_hb_s;

   hbp_hb_s            st_reg;
   hbp_hb_s            st_next;
   hbp_pkg::hbp_mode_e mode;
   logic               mode_valid;
   logic               ale_fall;
   logic               muxed;
   logic               read_act;
   logic               write_act;
   logic               cs_any;
   logic [7:0]         cur_addr;
   logic [8:0]         dec_now;
   logic [8:0]         dec_acc;
   logic               wr_dir;
   logic               wr_bidir;
   logic               commit;
   logic [3:0]         gp_dir;
   logic [3:0]         gp_rd;

   //---------------------------------------------------------------
   // Address decode and read data selection
   //---------------------------------------------------------------
   // Result is {hit, index}
   function automatic logic [8:0] decode_index(
      input logic [7:0] addr,
      input logic       mux_mode,
      input logic       even_sel
   );
      logic [8:0] res;
      res = {1'b1, addr};
      if (mux_mode && !even_sel) begin
         res = {~addr[0], 1'b0, addr[7:1]};
      end
      return res;
   endfunction

   function automatic logic [7:0] read_select(
      input logic [8:0] dec,
      input logic [7:0] ext,
      input logic [3:0] dir,
      input logic [3:0] bidir,
      input logic [7:0] input_port_data,
      input logic       mux_mode
   );
      logic [7:0] res;
      res = 8'h00;
      if (dec[8]) begin
         unique case (dec[7:0])
            hbp_pkg::OFS_EXT_MODE:   res = ext;
            hbp_pkg::OFS_PORT_DIR:   res = {4'h0, dir};
            hbp_pkg::OFS_BIDIR_DATA: res = {4'h0, bidir};
            hbp_pkg::OFS_INPUT_PORT: res = mux_mode ? input_port_data : 8'h00;
            default:                 res = 8'h00;
         endcase
      end
      return res;
   endfunction

   //---------------------------------------------------------------
   // Submodules
   //---------------------------------------------------------------
   hbp_mode_detect u_mode (
      .ref_clk_in     (ref_clk_in),
      .reset_in       (reset_in),
      .ale_in         (ale_in),
      .mode_out       (mode),
      .mode_valid_out (mode_valid),
      .ale_fall_out   (ale_fall)
   );

   hbp_gp_port #(
      .GP_W (4)
   ) u_gp (
      .ref_clk_in  (ref_clk_in),
      .reset_in    (reset_in),
      .wr_dir_in   (wr_dir),
      .wr_data_in  (wr_bidir),
      .wdata_in    (st_reg.wdata[3:0]),
      .pins_in     (gp_pins_in),
      .pins_out    (gp_pins_out),
      .pins_oe_out (gp_pins_oe_out),
      .dir_out     (gp_dir),
      .data_rd_out (gp_rd)
   );

   //---------------------------------------------------------------
   // Strobe interpretation
   //---------------------------------------------------------------
   assign muxed  = (mode == hbp_pkg::HBP_MODE_MUX);
   assign cs_any = ~st_reg.csa_s2 | ~st_reg.csb_s2;

   always_comb begin
      if (mode == hbp_pkg::HBP_MODE_DEMUX_DS) begin
         // Data strobe qualified by the read/write select
         read_act  = ~st_reg.str_s2 & st_reg.wrp_s2;
         write_act = ~st_reg.str_s2 & ~st_reg.wrp_s2;
      end else begin
         read_act  = ~st_reg.str_s2;
         write_act = ~st_reg.wrp_s2;
      end
      read_act  = read_act & cs_any & mode_valid;
      write_act = write_act & cs_any & mode_valid & ~read_act;
   end

   assign cur_addr = muxed ? st_reg.addr_lat : st_reg.addr_s2;
   assign dec_now  = decode_index(cur_addr, muxed,
                                  st_reg.ext_mode[hbp_pkg::EVEN_SEL_BIT]);
   assign dec_acc  = decode_index(st_reg.acc_addr, muxed,
                                  st_reg.ext_mode[hbp_pkg::EVEN_SEL_BIT]);

   //---------------------------------------------------------------
   // Access sequencing
   //---------------------------------------------------------------
   // Writes commit at the trailing strobe edge with the last data seen
   // while the strobe was active, so data may settle late in the cycle.
   always_comb begin
      st_next         = st_reg;
      st_next.addr_s1 = addr_port_pins_in;
      st_next.addr_s2 = st_reg.addr_s1;
      st_next.ad_s1   = muxed_addr_data_bus_in;
      st_next.ad_s2   = st_reg.ad_s1;
      st_next.csa_s1  = chip_select_group_a_n_in;
      st_next.csa_s2  = st_reg.csa_s1;
      st_next.csb_s1  = chip_select_group_b_n_in;
      st_next.csb_s2  = st_reg.csb_s1;
      st_next.str_s1  = rd_data_strobe_n_in;
      st_next.str_s2  = st_reg.str_s1;
      st_next.wrp_s1  = wr_or_rw_in;
      st_next.wrp_s2  = st_reg.wrp_s1;
      st_next.b_rd    = 1'b0;
      st_next.b_wr    = 1'b0;
      commit          = 1'b0;
      wr_dir          = 1'b0;
      wr_bidir        = 1'b0;
      if (ale_fall) begin
         st_next.addr_lat = st_reg.ad_s2;
      end
      unique case (st_reg.phase)
         hbp_pkg::HBP_PH_IDLE: begin
            st_next.acc_addr = cur_addr;
            st_next.grp_b    = st_reg.csa_s2; // group A wins a tie
            if (read_act) begin
               st_next.phase     = hbp_pkg::HBP_PH_READ;
               st_next.input_port_data_lat = st_reg.addr_s2;
               st_next.drive     = 1'b1;
               st_next.b_rd      = st_reg.csa_s2;
               st_next.rdata     = read_select(dec_now, st_reg.ext_mode,
                                      gp_dir, gp_rd, st_reg.addr_s2, muxed);
            end else if (write_act) begin
               st_next.phase = hbp_pkg::HBP_PH_WRITE;
               st_next.wdata = st_reg.ad_s2;
            end
         end
         hbp_pkg::HBP_PH_READ: begin
            if (st_reg.grp_b) begin
               st_next.rdata = grp_b_rdata_in;
            end else begin
               st_next.rdata = read_select(dec_acc, st_reg.ext_mode,
                                  gp_dir, gp_rd, st_reg.input_port_data_lat, muxed);
            end
            if (!read_act) begin
               st_next.phase = hbp_pkg::HBP_PH_IDLE;
               st_next.drive = 1'b0;
            end
         end
         hbp_pkg::HBP_PH_WRITE: begin
            if (write_act) begin
               st_next.wdata = st_reg.ad_s2;
            end else begin
               st_next.phase = hbp_pkg::HBP_PH_IDLE;
               commit        = 1'b1;
            end
         end
      endcase
      if (commit && st_reg.grp_b) begin
         st_next.b_wr = 1'b1;
      end else if (commit && dec_acc[8]) begin
         unique case (dec_acc[7:0])
            hbp_pkg::OFS_EXT_MODE:   st_next.ext_mode = st_reg.wdata;
            hbp_pkg::OFS_PORT_DIR:   wr_dir = 1'b1;
            hbp_pkg::OFS_BIDIR_DATA: wr_bidir = 1'b1;
            default: ; // Input port and holes take no write
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_reg          <= '0;
         st_reg.csa_s1   <= 1'b1;
         st_reg.csa_s2   <= 1'b1;
         st_reg.csb_s1   <= 1'b1;
         st_reg.csb_s2   <= 1'b1;
         st_reg.str_s1   <= 1'b1;
         st_reg.str_s2   <= 1'b1;
         st_reg.wrp_s1   <= 1'b1;
         st_reg.wrp_s2   <= 1'b1;
         st_reg.phase    <= hbp_pkg::HBP_PH_IDLE;
         st_reg.ext_mode <= hbp_pkg::RST_EXT_MODE;
      end else begin
         st_reg <= st_next;
      end
   end

   //---------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------
   assign muxed_addr_data_bus_out    = st_reg.rdata;
   assign muxed_addr_data_bus_oe_out = {8{st_reg.drive}};
   assign grp_b_rd_out               = st_reg.b_rd;
   assign grp_b_wr_out               = st_reg.b_wr;
   assign grp_b_addr_out             = st_reg.acc_addr;
   assign grp_b_wdata_out            = st_reg.wdata;

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   a_even_only: assert property (
      (commit && !st_reg.grp_b && muxed && st_reg.acc_addr[0] &&
       !st_reg.ext_mode[hbp_pkg::EVEN_SEL_BIT]) |=>
         $stable(st_reg.ext_mode) && $stable(gp_dir) && $stable(gp_pins_out))
      else $error("odd address decoded in even-only muxed mode");

   a_read_drive: assert property (
      (st_reg.phase == hbp_pkg::HBP_PH_IDLE && read_act) |=>
         muxed_addr_data_bus_oe_out == 8'hFF)
      else $error("read did not drive the data bus");

   a_read_release: assert property (
      (st_reg.phase == hbp_pkg::HBP_PH_READ && !read_act) |=>
         muxed_addr_data_bus_oe_out == 8'h00)
      else $error("data bus not released after read");

   a_input_port_data_latch: assert property (
      (st_reg.phase == hbp_pkg::HBP_PH_IDLE && read_act) |=>
         st_reg.input_port_data_lat == $past(st_reg.addr_s2) ##1
         $stable(st_reg.input_port_data_lat))
      else $error("input port not latched at strobe fall");

   a_input_port_data_return: assert property (
      (st_reg.phase == hbp_pkg::HBP_PH_READ && !st_reg.grp_b &&
       dec_acc == {1'b1, hbp_pkg::OFS_INPUT_PORT}) |=>
         muxed_addr_data_bus_out == (muxed ? $past(st_reg.input_port_data_lat) : 8'h00))
      else $error("input port read returned wrong value");

   a_input_port_data_no_write: assert property (
      (commit && !st_reg.grp_b &&
       dec_acc == {1'b1, hbp_pkg::OFS_INPUT_PORT}) |=>
         $stable(st_reg.ext_mode) && $stable(gp_dir) && $stable(gp_pins_out))
      else $error("write to input port changed state");

   a_grp_b_route: assert property (
      (commit && st_reg.grp_b) |=> grp_b_wr_out ##1 !grp_b_wr_out)
      else $error("group B write not forwarded as one pulse");

   c_read_a: cover property (
      st_reg.phase == hbp_pkg::HBP_PH_READ && !st_reg.grp_b);
   c_write_a: cover property (commit && !st_reg.grp_b && dec_acc[8]);
   c_mux_input_port_data: cover property (
      muxed && st_reg.phase == hbp_pkg::HBP_PH_READ &&
      dec_acc == {1'b1, hbp_pkg::OFS_INPUT_PORT});
   c_grp_b: cover property (grp_b_wr_out);

endmodule

`default_nettype wire

/* File: testbench/hbp_host_model.sv */
// Host processor model driving the bus pins in all three bus styles
`timescale 1ns/10ps
`default_nettype none

module hbp_host_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] ad_out_in,
   input  wire logic [7:0] ad_oe_in,
   output logic            ale_out,
   output logic            cs_a_n_out,
   output logic            cs_b_n_out,
   output logic            strb_n_out,
   output logic            wr_rw_out,
   output logic      [7:0] addr_out,
   output logic      [7:0] ad_in_out
);
   logic [1:0] style = 2'h0; // 0 read/write strobes, 1 data strobe, 2 muxed
   logic [7:0] port_pins = 8'h00;
   logic [7:0] addr_q = 8'h00;
   logic [7:0] ad_q = 8'h00;
   logic       drv = 1'b0;
   initial begin
      ale_out = 1'b0;
      cs_a_n_out = 1'b1;
      cs_b_n_out = 1'b1;
      strb_n_out = 1'b1;
      wr_rw_out = 1'b1;
   end
   // Address pins become the input port in muxed mode
   assign addr_out = (style == 2'h2) ? port_pins : addr_q;
   // A released bus shows the inverse of the last value, never a stale copy
   assign ad_in_out = drv ? ad_q : ((ad_oe_in != 8'h00) ? ad_out_in : ~ad_q);

   task automatic ale_pulse();
      ale_out = 1'b1;
      repeat (3) @(negedge clk_in);
      ale_out = 1'b0;
      repeat (5) @(negedge clk_in);
   endtask

   task automatic access(input logic rd, input logic grp_b,
                         input logic [7:0] a, input logic [7:0] wd,
                         output logic [7:0] q, output logic [7:0] qoe);
      @(negedge clk_in);
      if (style == 2'h2) begin
         ad_q = a;
         drv = 1'b1;
         ale_pulse();
      end else begin
         addr_q = a;
      end
      drv = !rd;
      if (!rd) ad_q = wd;
      if (grp_b) cs_b_n_out = 1'b0;
      else cs_a_n_out = 1'b0;
      strb_n_out = (style != 2'h1 && !rd);
      wr_rw_out = (style == 2'h1) ? rd : rd;
      // Sample mid-cycle, where the read data has settled
      repeat (6) @(negedge clk_in);
      q = ad_in_out;
      qoe = ad_oe_in;
      strb_n_out = 1'b1;
      wr_rw_out = 1'b1;
      cs_a_n_out = 1'b1;
      cs_b_n_out = 1'b1;
      repeat (5) @(negedge clk_in);
      drv = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: testbench/host_bus_and_parallel_ports_tb_top.sv */
// Self-checking testbench of the host bus and parallel port block
`timescale 1ns/10ps
`default_nettype none

module host_bus_and_parallel_ports_tb_top;
   logic       ref_clk_in, reset_in;
   logic       ale, cs_a_n, cs_b_n, strb_n, wr_rw, b_rd, b_wr;
   logic [7:0] addr, ad_in, ad_out, ad_oe, b_addr, b_wd, b_rdata;
   logic [3:0] gp_ext, gp_out, gp_oe, gp_wire;
   logic [7:0] q, qoe, b_wd_seen, b_addr_seen;
   int         mismatches, checks, wr_pulses, rd_pulses;

   assign gp_wire = (gp_oe & gp_out) | (~gp_oe & gp_ext);

   hbp_host_bus u_hbp_host_bus (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .ale_in(ale),
      .chip_select_group_a_n_in(cs_a_n), .chip_select_group_b_n_in(cs_b_n),
      .rd_data_strobe_n_in(strb_n), .wr_or_rw_in(wr_rw),
      .addr_port_pins_in(addr), .muxed_addr_data_bus_in(ad_in),
      .muxed_addr_data_bus_out(ad_out), .muxed_addr_data_bus_oe_out(ad_oe),
      .gp_pins_in(gp_wire), .gp_pins_out(gp_out), .gp_pins_oe_out(gp_oe),
      .grp_b_rd_out(b_rd), .grp_b_wr_out(b_wr), .grp_b_addr_out(b_addr),
      .grp_b_wdata_out(b_wd), .grp_b_rdata_in(b_rdata));

   hbp_host_model u_hbp_host_model (
      .clk_in(ref_clk_in), .ad_out_in(ad_out), .ad_oe_in(ad_oe),
      .ale_out(ale), .cs_a_n_out(cs_a_n), .cs_b_n_out(cs_b_n),
      .strb_n_out(strb_n), .wr_rw_out(wr_rw), .addr_out(addr),
      .ad_in_out(ad_in));

   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) if (b_wr === 1'b1) begin
      wr_pulses++;
      b_wd_seen <= b_wd;
      b_addr_seen <= b_addr;
   end

   always @(posedge ref_clk_in) if (b_rd === 1'b1) rd_pulses++;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string n, input logic [7:0] s, e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic rd(input logic g, input logic [7:0] a, e, input string n);
      u_hbp_host_model.access(1'b1, g, a, 8'h00, q, qoe);
      check(n, q, e);
      check({n, "_oe"}, qoe, 8'hFF);
      check({n, "_rel"}, ad_oe, 8'h00);
   endtask

   task automatic wr(input logic g, input logic [7:0] a, d);
      u_hbp_host_model.access(1'b0, g, a, d, q, qoe);
   endtask

   task automatic do_reset(input logic [1:0] s);
      @(negedge ref_clk_in);
      reset_in = 1'b1;
      u_hbp_host_model.style = s;
      // Strobe style needs the latch enable pin strapped high
      u_hbp_host_model.ale_out = (s == 2'h1);
      repeat (3) @(negedge ref_clk_in);
      reset_in = 1'b0;
      repeat (10) @(negedge ref_clk_in);
      if (s == 2'h2) u_hbp_host_model.ale_pulse();
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk_in);
      mismatches++;
      finish_test();
   end

   initial begin
      reset_in = 1'b1;
      gp_ext = 4'hA;
      b_rdata = 8'h00;
      mismatches = 0;
      checks = 0;
      wr_pulses = 0;
      rd_pulses = 0;
      do_reset(2'h0);
      check("oe_reset", {4'h0, gp_oe}, 8'h00);
      rd(1'b0, hbp_pkg::OFS_BIDIR_DATA, 8'h0A, "pins_in");
      rd(1'b0, hbp_pkg::OFS_PORT_DIR, 8'h00, "dir_reset");
      wr(1'b0, hbp_pkg::OFS_PORT_DIR, 8'h05);
      wr(1'b0, hbp_pkg::OFS_BIDIR_DATA, 8'h0F);
      check("gp_oe", {4'h0, gp_oe}, 8'h05);
      check("gp_out", {4'h0, gp_out & gp_oe}, 8'h05);
      gp_ext = 4'h0;
      rd(1'b0, hbp_pkg::OFS_BIDIR_DATA, 8'h05, "mixed_dir");
      wr(1'b0, hbp_pkg::OFS_INPUT_PORT, 8'hFF);
      rd(1'b0, hbp_pkg::OFS_INPUT_PORT, 8'h00, "in_port_demux");
      rd(1'b0, 8'h10, 8'h00, "unmapped");
      b_rdata = 8'h3C;
      rd(1'b1, 8'h45, 8'h3C, "grp_b_rd");
      check("b_rd_pulses", rd_pulses[7:0], 8'h01);
      wr(1'b1, 8'h46, 8'h9A);
      check("b_pulses", wr_pulses[7:0], 8'h01);
      check("b_wdata", b_wd_seen, 8'h9A);
      check("b_addr", b_addr_seen, 8'h46);
      do_reset(2'h1);
      wr(1'b0, hbp_pkg::OFS_PORT_DIR, 8'h03);
      rd(1'b0, hbp_pkg::OFS_PORT_DIR, 8'h03, "strobe_style");
      check("gp_oe_ds", {4'h0, gp_oe}, 8'h03);
      do_reset(2'h2);
      u_hbp_host_model.port_pins = 8'hA5;
      rd(1'b0, 8'h06, 8'hA5, "in_port_mux");
      rd(1'b0, 8'h07, 8'h00, "odd_addr");
      wr(1'b0, 8'h02, 8'h0C);
      wr(1'b0, 8'h03, 8'h0F);
      rd(1'b0, 8'h02, 8'h0C, "even_map");
      wr(1'b0, 8'h00, 8'h01);
      rd(1'b0, 8'h03, 8'hA5, "align_map");
      finish_test();
   end
endmodule
`default_nettype wire
